// ---- rtl/two_wire_unit.v ----
// Two-wire unit slave engine with status, data, own address and address mask registers.
//
// Implementation choice: the address-and-strobe port.
`default_nettype none
`include "two_wire_unit_defines.vh"

module two_wire_unit (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   // Serial bus pins
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe,
   // Prescaler select toward the bit-rate generator
   output wire [1:0] rate_prescale_sel,
   // Interrupt
   output wire       irq
);

   // ----------------------------------------------------------------
   // Engine states
   // ----------------------------------------------------------------
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_ADDR = 6'h02;
   localparam [5:0] S_AACK = 6'h04;
   localparam [5:0] S_RXD  = 6'h08;
   localparam [5:0] S_TXD  = 6'h10;
   localparam [5:0] S_DACK = 6'h20;

   // Masked address compare, with optional broadcast match.
   function addr_hit;
      input [6:0] rx;
      input [7:0] own;
      input [7:0] msk;
      begin
         addr_hit = (((rx ^ own[7:1]) & ~msk[7:1]) == 7'h00) || (own[0] && rx == 7'h00);
      end
   endfunction

   // Registers.
   reg [4:0] status_code_r;
   reg [1:0] rate_prescale_sel_r;
   reg [7:0] shift_data_r;
   reg [7:0] own_slave_address_r;
   reg [7:0] slave_address_mask_r;
   reg       job_done_flag_r;
   reg       write_collision_flag_r;
   reg       ack_en_r;
   reg       unit_en_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_mask_r;
   reg [5:0] state_r;
   reg [3:0] bit_cnt_r;
   reg       is_read_r;
   reg       sda_drive_low_r;
   reg [1:0] scl_sync_r;
   reg [1:0] sda_sync_r;
   reg       scl_q_r;
   reg       sda_q_r;
   reg [6:0] addr_sh_r;

   // Pin inputs pass two flops before use.
   always @(posedge clk) begin
      if (!rst_n) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_q_r    <= 1'b1;
         sda_q_r    <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
         scl_q_r    <= scl_sync_r[1];
         sda_q_r    <= sda_sync_r[1];
      end
   end

   wire scl_s    = scl_sync_r[1];
   wire sda_s    = sda_sync_r[1];
   wire scl_rise = scl_s & ~scl_q_r;
   wire scl_fall = ~scl_s & scl_q_r;
   wire start_c  = scl_s & scl_q_r & ~sda_s & sda_q_r;
   wire stop_c   = scl_s & scl_q_r & sda_s & ~sda_q_r;

   // Register strobes.
   wire wr_status = wr && addr == `TW_OFS_STATUS;
   wire wr_own    = wr && addr == `TW_OFS_OWNADDR;
   wire wr_data   = wr && addr == `TW_OFS_DATA;
   wire wr_ctrl   = wr && addr == `TW_OFS_CTRL;
   wire wr_mask   = wr && addr == `TW_OFS_MASK;
   wire wr_istat  = wr && addr == `TW_OFS_IRQ_STAT;
   wire wr_imask  = wr && addr == `TW_OFS_IRQ_MASK;
   wire release_w = wr_ctrl && wdata[`TW_CTRL_DONE] && job_done_flag_r;

   // Engine events.
   reg       ev_done;
   reg       ev_match;
   reg       ev_lost;

   // Slave engine: address receive, ack, data shift, clock stretch.
   always @(posedge clk) begin
      if (!rst_n) begin
         state_r         <= S_IDLE;
         bit_cnt_r       <= 4'h0;
         is_read_r       <= 1'b0;
         sda_drive_low_r <= 1'b0;
         status_code_r   <= `TW_RST_STATUS;
         job_done_flag_r <= 1'b0;
         shift_data_r    <= `TW_RST_DATA;
         ev_done         <= 1'b0;
         ev_match        <= 1'b0;
         ev_lost         <= 1'b0;
      end else begin
         ev_done  <= 1'b0;
         ev_match <= 1'b0;
         ev_lost  <= 1'b0;
         // Data loads only while job done holds the clock low.
         if (wr_data && job_done_flag_r)
            shift_data_r <= wdata;
         if (release_w)
            job_done_flag_r <= 1'b0;
         if (!unit_en_r) begin
            state_r         <= S_IDLE;
            sda_drive_low_r <= 1'b0;
            status_code_r   <= `TW_ST_IDLE;
         end else if (stop_c) begin
            state_r         <= S_IDLE;
            sda_drive_low_r <= 1'b0;
            status_code_r   <= `TW_ST_IDLE;
         end else if (start_c) begin
            // A start seen outside idle and the address byte is a lost bus; keep the partial byte.
            if (state_r != S_IDLE && state_r != S_ADDR)
               ev_lost <= 1'b1;
            state_r         <= S_ADDR;
            bit_cnt_r       <= 4'h0;
            sda_drive_low_r <= 1'b0;
         end else if (!job_done_flag_r) begin
            case (state_r)
               S_ADDR: begin
                  if (scl_rise) begin
                     // Address bits collect in a separate path to keep data intact.
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                     if (bit_cnt_r == 4'h7) begin
                        is_read_r <= sda_s;
                        if (addr_hit(addr_sh_r, own_slave_address_r,
                                     slave_address_mask_r) && ack_en_r) begin
                           state_r  <= S_AACK;
                           ev_match <= 1'b1;
                           status_code_r <= sda_s ? `TW_ST_SLA_R :
                              (addr_sh_r == 7'h00 && own_slave_address_r[0]) ?
                              `TW_ST_GCALL : `TW_ST_SLA_W;
                        end else begin
                           state_r <= S_IDLE;
                        end
                     end
                  end
               end
               S_AACK: begin
                  // Acknowledge driven by hardware only.
                  if (scl_fall && !sda_drive_low_r)
                     sda_drive_low_r <= 1'b1;
                  else if (scl_fall) begin
                     sda_drive_low_r <= 1'b0;
                     bit_cnt_r       <= 4'h0;
                     job_done_flag_r <= 1'b1;
                     ev_done         <= 1'b1;
                     state_r         <= is_read_r ? S_TXD : S_RXD;
                  end
               end
               S_RXD: begin
                  if (scl_rise) begin
                     shift_data_r <= {shift_data_r[6:0], sda_s};
                     bit_cnt_r    <= bit_cnt_r + 4'h1;
                     if (bit_cnt_r == 4'h7) begin
                        state_r       <= S_DACK;
                        status_code_r <= `TW_ST_RX_DATA;
                     end
                  end
               end
               S_TXD: begin
                  // Drive msb after the clock falls; the bus value is shifted back in on the rising clock.
                  if (scl_fall || bit_cnt_r == 4'h0)
                     sda_drive_low_r <= ~shift_data_r[7];
                  if (scl_rise) begin
                     shift_data_r <= {shift_data_r[6:0], sda_s};
                     bit_cnt_r    <= bit_cnt_r + 4'h1;
                     if (bit_cnt_r == 4'h7) begin
                        state_r       <= S_DACK;
                        status_code_r <= `TW_ST_TX_DATA;
                     end
                  end
               end
               S_DACK: begin
                  // Ninth bit: ack a received byte, or free the line for the master's ack.
                  if (scl_fall && bit_cnt_r == 4'h8) begin
                     sda_drive_low_r <= ~is_read_r & ack_en_r;
                     bit_cnt_r       <= 4'h9;
                  end else if (scl_fall) begin
                     sda_drive_low_r <= 1'b0;
                     bit_cnt_r       <= 4'h0;
                     job_done_flag_r <= 1'b1;
                     ev_done         <= 1'b1;
                     state_r         <= is_read_r ? S_TXD : S_RXD;
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end

   // Address shifter used only during the address phase.
   always @(posedge clk) begin
      if (!rst_n)
         addr_sh_r <= 7'h00;
      else if (state_r == S_ADDR && scl_rise && bit_cnt_r < 4'h7)
         addr_sh_r <= {addr_sh_r[5:0], sda_s};
   end

   // Software registers and the collision flag.
   always @(posedge clk) begin
      if (!rst_n) begin
         rate_prescale_sel_r    <= 2'h0;
         own_slave_address_r    <= `TW_RST_OWNADDR;
         slave_address_mask_r   <= `TW_RST_MASK;
         write_collision_flag_r <= 1'b0;
         ack_en_r               <= 1'b0;
         unit_en_r              <= 1'b0;
         irq_mask_r             <= 3'h0;
      end else begin
         if (wr_status)
            rate_prescale_sel_r <= wdata[1:0];
         if (wr_own)
            own_slave_address_r <= wdata;
         if (wr_mask)
            slave_address_mask_r <= {wdata[7:1], 1'b0};
         if (wr_data)
            write_collision_flag_r <= ~job_done_flag_r;
         if (wr_ctrl) begin
            ack_en_r  <= wdata[`TW_CTRL_ACKEN];
            unit_en_r <= wdata[`TW_CTRL_EN];
         end
         if (wr_imask)
            irq_mask_r <= wdata[2:0];
      end
   end

   // Sticky interrupt status; a new event wins over a clear.
   always @(posedge clk) begin
      if (!rst_n)
         irq_stat_r <= 3'h0;
      else
         irq_stat_r <= (irq_stat_r & ~(wr_istat ? wdata[2:0] : 3'h0))
                       | {ev_lost, ev_match, ev_done};
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // Read data, one cycle after the strobe.
   always @(posedge clk) begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (rd) begin
         if (addr == `TW_OFS_STATUS)
            rdata <= {status_code_r, 1'b0, rate_prescale_sel_r};
         else if (addr == `TW_OFS_OWNADDR)
            rdata <= own_slave_address_r;
         else if (addr == `TW_OFS_DATA)
            // No sleep mode here, so data always keeps its content: the last bus byte, the byte written for sending, or a partly shifted byte.
            rdata <= shift_data_r;
         else if (addr == `TW_OFS_CTRL)
            rdata <= {job_done_flag_r, ack_en_r, 2'h0, write_collision_flag_r,
                      unit_en_r, 2'h0};
         else if (addr == `TW_OFS_MASK)
            rdata <= slave_address_mask_r;
         else if (addr == `TW_OFS_IRQ_STAT)
            rdata <= {5'h00, irq_stat_r};
         else if (addr == `TW_OFS_IRQ_MASK)
            rdata <= {5'h00, irq_mask_r};
         else
            rdata <= 8'h00;
      end else
         rdata <= 8'h00;
   end

   // Open-drain pins: clock held low while job done is set and the unit is enabled.
   assign scl_out           = 1'b0;
   assign scl_oe            = job_done_flag_r & unit_en_r;
   assign sda_out           = 1'b0;
   assign sda_oe            = sda_drive_low_r & unit_en_r;
   assign rate_prescale_sel = rate_prescale_sel_r;

endmodule
`default_nettype wire

// ---- rtl/two_wire_unit_defines.vh ----
// Register offsets, field positions, reset values and codes of the two-wire unit status/data part.
//
// Operation
// - Status upper five bits show read-only state.
// - Reserved status bit 2, mask bit 0 read zero.
// - Low status bits select prescaler 1/4/16/64.
// - Data holds next byte sent or last received.
// - Data writable only while job done is set.
// - Data stays stable while job done is set.
// - Shifting out also shifts in bus data.
// - After sleep wake-up data content is undefined.
// - Lost arbitration keeps the byte in progress.
// - Acknowledge handled by hardware, no CPU access.
// - Own address upper seven bits, slave use only.
// - Address bit 0 enables general call recognition.
// - Comparator matches received address, raises interrupt request.
// - Set mask bits ignore matching address bit compare.
// - Job done set at completion, holds clock low.
// - Data write without job done sets collision flag.
`ifndef TWO_WIRE_UNIT_DEFINES_VH
`define TWO_WIRE_UNIT_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TW_OFS_STATUS    8'hB9
`define TW_OFS_OWNADDR   8'hBA
`define TW_OFS_DATA      8'hBB
`define TW_OFS_CTRL      8'hBC
`define TW_OFS_MASK      8'hBD
`define TW_OFS_IRQ_STAT  8'hBE
`define TW_OFS_IRQ_MASK  8'hBF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TW_RST_OWNADDR   8'hFE
`define TW_RST_DATA      8'hFF
`define TW_RST_MASK      8'h00
`define TW_RST_STATUS    5'h1F

// ----------------------------------------------------------------
// Field positions and control bits
// ----------------------------------------------------------------
`define TW_CTRL_DONE     7
`define TW_CTRL_ACKEN    6
`define TW_CTRL_COLL     3
`define TW_CTRL_EN       2
`define TW_IRQ_DONE      0
`define TW_IRQ_MATCH     1
`define TW_IRQ_LOST      2

// ----------------------------------------------------------------
// Status codes (upper five bits)
// ----------------------------------------------------------------
`define TW_ST_IDLE       5'h1F
`define TW_ST_SLA_W      5'h0C
`define TW_ST_GCALL      5'h0E
`define TW_ST_SLA_R      5'h15
`define TW_ST_RX_DATA    5'h10
`define TW_ST_TX_DATA    5'h17
`define TW_ST_LOST       5'h0F

`endif

// ---- verif/two_wire_unit_asserts.sv ----
// Concurrent checks on the two-wire unit register port and pins.
`default_nettype none
module two_wire_unit_asserts (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // Pins and interrupt
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic [1:0] rate_prescale_sel,
   input wire logic       irq
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic bc_wr;
   // A control write is the only thing allowed to release the stretch.
   assign bc_wr = wr && addr == 8'hBC;
   // A read at one address, ending in the cycle where its data stand.
   sequence s_rd(a);
      rd && addr == a ##1 1'b1;
   endsequence
   property p_psel;
      logic [1:0] v;
      (wr && addr == 8'hB9, v = wdata[1:0]) |=> rate_prescale_sel == v;
   endproperty
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_status_low: assert property (s_rd(8'hB9) |-> rdata[2:0] == {1'b0, rate_prescale_sel})
      else $error("status low bits wrong");
   a_mask_rsvd: assert property (s_rd(8'hBD) |-> !rdata[0])
      else $error("mask bit 0 not zero");
   a_psel_write: assert property (p_psel)
      else $error("prescale select not written");
   a_irq_masked: assert property (wr && addr == 8'hBF && wdata == 8'h00 |=> !irq)
      else $error("interrupt high with all masked");
   a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("open drain output driven high");
   a_stretch_end: assert property ($fell(scl_oe) |-> $past(bc_wr) || $past(bc_wr, 2))
      else $error("clock stretch ended without control write");
   a_sda_steady: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
      |-> $stable(sda_oe))
      else $error("data line changed while clock high");
endmodule

bind two_wire_unit two_wire_unit_asserts u_chk (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_out(sda_out), .sda_oe(sda_oe), .rate_prescale_sel(rate_prescale_sel), .irq(irq)
);
`default_nettype wire

// ---- verif/bus_master_model.sv ----
// Behavioural two-wire bus master on the far side of the unit.
`default_nettype none
module bus_master_model (
   // Unit pin enables
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   // Resolved line levels
   output wire logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_low;
   logic sda_low;
   // Pull-ups on both lines; whoever pulls low wins.
   assign scl = !(scl_low || scl_oe);
   assign sda = !(sda_low || sda_oe);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // One bit: data set while the clock is low, sampled while high.
   task automatic bit_io(input logic b, output logic s);
      sda_low = !b;
      #50;
      scl_low = 1'b0;
      wait (scl === 1'b1); // The unit may still stretch the clock.
      #100;
      s = sda;
      scl_low = 1'b1;
      #50;
   endtask
   // Start: data falls while the clock is high.
   task automatic start_cond;
      sda_low = 1'b1;
      #100;
      scl_low = 1'b1;
      #50;
   endtask
   // Stop: data rises while the clock is high, then the bus idles.
   task automatic stop_cond;
      sda_low = 1'b1;
      #50;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #100;
      sda_low = 1'b0;
      #100;
   endtask
   // Eight bits out and in, most significant first, then the ninth.
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, ack);
   endtask
endmodule
`default_nettype wire

// ---- verif/two_wire_unit_test.sv ----
// Self-checking bench for the two-wire unit registers and slave engine.
`default_nettype none
module two_wire_unit_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk;
   logic       rst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   wire  [7:0] rdata;
   wire        scl_oe;
   wire        sda_oe;
   wire        scl;
   wire        sda;
   wire  [1:0] psel;
   wire        irq;
   int         fails;
   int         checks;
   int         cyc;
   logic [7:0] q;
   logic       ack;
   two_wire_unit dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .rate_prescale_sel(psel), .irq(irq));
   bus_master_model bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // ---------------------------------------------
   // Clock, watchdog and shared tasks
   // ---------------------------------------------
   always #12.5 clk = ~clk;
   // A hang counts as a mismatch and ends the run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      rd_reg(a, q);
      chk(q, e);
   endtask
   task automatic wait_irq;
      for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
      #1 chk(8'(irq), 8'h01);
   endtask
   // Clear all events, then let the stretched job go on.
   task automatic release_job;
      wr_reg(8'hBE, 8'h07);
      wr_reg(8'hBC, 8'hC4);
   endtask
   // Start and address byte; on a match, check the job and its status code.
   task automatic addr_phase(input logic [7:0] b, input logic nak, input logic [7:0] st);
      bus.start_cond();
      bus.byte_io(b, q, ack);
      chk(8'(ack), 8'(nak));
      if (!nak) begin
         wait_irq();
         repeat (4) @(posedge clk);
         chk(8'(scl_oe), 8'h01);
         rd_reg(8'hB9, q);
         chk(q & 8'hF8, st);
      end
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_regs;
      rd_chk(8'hB9, 8'hF8);
      rd_chk(8'hBA, 8'hFE);
      rd_chk(8'hBB, 8'hFF);
      rd_chk(8'hBD, 8'h00);
      rd_chk(8'h10, 8'h00);
      for (logic [7:0] i = 0; i < 4; i++) begin
         wr_reg(8'hB9, 8'hFC | i);
         rd_chk(8'hB9, 8'hF8 | i);
         chk(8'(psel), i);
      end
      wr_reg(8'hBD, 8'hFF);
      rd_chk(8'hBD, 8'hFE);
      wr_reg(8'hBD, 8'h00);
      wr_reg(8'hBB, 8'h5A);
      rd_chk(8'hBB, 8'hFF);
      rd_reg(8'hBC, q);
      chk(q & 8'h08, 8'h08);
      $display("registers done");
   endtask
   task automatic t_rx;
      wr_reg(8'hBA, 8'hA4);
      wr_reg(8'hBF, 8'h03);
      wr_reg(8'hBC, 8'h44);
      addr_phase(8'hA4, 1'b0, 8'h60);
      wr_reg(8'hBB, 8'h5A);
      rd_chk(8'hBB, 8'h5A);
      rd_reg(8'hBC, q);
      chk(q & 8'h88, 8'h80);
      wr_reg(8'hBF, 8'h00);
      #1 chk(8'(irq), 8'h00);
      wr_reg(8'hBF, 8'h03);
      rd_chk(8'hBB, 8'h5A);
      release_job();
      bus.byte_io(8'h3C, q, ack);
      chk(8'(ack), 8'h00);
      wait_irq();
      rd_chk(8'hBB, 8'h3C);
      rd_reg(8'hB9, q);
      chk(q & 8'hF8, 8'h80);
      release_job();
      bus.stop_cond();
      rd_reg(8'hB9, q);
      chk(q & 8'hF8, 8'hF8);
      $display("receive done");
   endtask
   task automatic t_tx;
      addr_phase(8'hA5, 1'b0, 8'hA8);
      wr_reg(8'hBB, 8'hC3);
      release_job();
      bus.byte_io(8'hFF, q, ack);
      chk(q, 8'hC3);
      repeat (20) @(posedge clk);
      release_job();
      bus.stop_cond();
      $display("transmit done");
   endtask
   task automatic t_match;
      wr_reg(8'hBA, 8'hA1);
      wr_reg(8'hBD, 8'h04);
      addr_phase(8'hA4, 1'b0, 8'h60);
      release_job();
      bus.stop_cond();
      wr_reg(8'hBD, 8'h00);
      addr_phase(8'hA4, 1'b1, 8'h00);
      bus.stop_cond();
      addr_phase(8'h00, 1'b0, 8'h70);
      release_job();
      bus.stop_cond();
      wr_reg(8'hBA, 8'hA0);
      addr_phase(8'h00, 1'b1, 8'h00);
      bus.stop_cond();
      $display("address match done");
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Reset for four cycles, then run every scenario.
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      fails = 0;
      checks = 0;
      cyc = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_rx();
      t_tx();
      t_match();
      tally_and_finish();
   end
endmodule
`default_nettype wire
